/* btg_pkg.sv */
// Shared constants and types for the billing tone generator
package btg_pkg;

  // ==========================================================
  // Register bus
  localparam int BTG_DW = 16;
  localparam int BTG_AW = 4;
  localparam logic [3:0] BTG_REG_CTRL = 4'h0;
  localparam logic [3:0] BTG_REG_FREQ = 4'h1;
  localparam logic [3:0] BTG_REG_AMP = 4'h2;
  localparam logic [3:0] BTG_REG_STEP = 4'h3;
  localparam logic [3:0] BTG_REG_CLIP = 4'h4;
  localparam logic [3:0] BTG_REG_ONCNT = 4'h5;
  localparam logic [3:0] BTG_REG_OFFCNT = 4'h6;
  localparam logic [3:0] BTG_REG_IRQFLAG = 4'h7;
  localparam logic [3:0] BTG_REG_IRQMASK = 4'h8;
  localparam logic [3:0] BTG_REG_VOLUME = 4'h9;

  // ==========================================================
  // Field positions
  localparam int BTG_CTRL_EN_BIT = 0;
  localparam int BTG_CTRL_ONT_BIT = 1;
  localparam int BTG_CTRL_OFFT_BIT = 2;
  localparam int BTG_CTRL_PRES_BIT = 3;
  localparam int BTG_CTRL_W = 3;
  localparam int BTG_IRQ_ON_BIT = 0;
  localparam int BTG_IRQ_OFF_BIT = 1;
  localparam int BTG_IRQ_W = 2;
  localparam int BTG_FREQ_LSB = 3;

  // ==========================================================
  // Reset values and arithmetic constants
  localparam logic [15:0] BTG_ZERO16 = 16'h0000;
  localparam logic [15:0] BTG_VOL_MAX = 16'h7fff;
  localparam logic [15:0] BTG_CNT_LAST = 16'h0001;
  localparam int BTG_COEFF_SHIFT = 13;
  localparam int BTG_VOL_SHIFT = 15;
  localparam logic signed [31:0] BTG_SAT_HI = 32'sh00007fff;
  localparam logic signed [31:0] BTG_SAT_LO = -32'sh00008000;

  // ==========================================================
  // Timing
  localparam int BTG_CLK_HZ = 100000000;
  localparam int BTG_SAMPLE_RATE_HZ = 64000;
  localparam int BTG_TICK_US = 125;
  localparam int BTG_SAMPLES_PER_TICK =
    BTG_SAMPLE_RATE_HZ * BTG_TICK_US / 1000000;
  localparam logic [2:0] BTG_SPT_LAST = 3'(BTG_SAMPLES_PER_TICK - 1);

  // ==========================================================
  // Cadence states
  typedef enum logic [1:0] {
    BTG_CAD_IDLE = 2'b00,
    BTG_CAD_ON = 2'b01,
    BTG_CAD_OFF = 2'b10
  } btg_cad_e;

endpackage

/* btg_osc.sv */
// Two-pole resonator producing the tone sinusoid
`timescale 1ns/1ps
module btg_osc (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic sample_en,
  input wire logic restart,
  input wire logic [15:0] coeff,
  input wire logic [15:0] amp,
  output logic signed [15:0] osc_out
);
  import btg_pkg::*;

  logic signed [15:0] y1;
  logic signed [15:0] y2;

  // ==========================================================
  // Recurrence y0 = 2*c*y1 - y2, c held in upper coefficient bits
  wire signed [15:0] c_w = {coeff[15:BTG_FREQ_LSB], BTG_FREQ_LSB'(0)};
  wire signed [31:0] prod_w = c_w * y1;
  wire signed [31:0] fb_w = (prod_w >>> BTG_COEFF_SHIFT) - 32'(y2);
  wire signed [15:0] y0_w = (fb_w > BTG_SAT_HI) ? BTG_SAT_HI[15:0] :
                            (fb_w < BTG_SAT_LO) ? BTG_SAT_LO[15:0] :
                            fb_w[15:0];

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      y1 <= '0;
      y2 <= '0;
    end else if (ce) begin
      if (restart) begin
        y1 <= amp;
        y2 <= '0;
      end else if (sample_en) begin
        y1 <= y0_w;
        y2 <= y1;
      end
    end
  end

  assign osc_out = y1;

  osc_shift_a: assert property (@(posedge core_clk) disable iff (rst)
    ce && sample_en && !restart |=> y2 == $past(y1) && y1 == $past(y0_w))
    else $error("oscillator did not advance");

endmodule

/* btg_top.sv */
// Billing tone generator: oscillator, envelope, cadence, registers
//
// Implementation choices: the register addresses and strobed register access.
`timescale 1ns/1ps
module btg_top #(
  parameter int CLK_HZ = btg_pkg::BTG_CLK_HZ
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [btg_pkg::BTG_AW-1:0] reg_addr,
  input wire logic [btg_pkg::BTG_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [btg_pkg::BTG_DW-1:0] reg_rdata,
  input wire logic signed [15:0] tx_level,
  output logic signed [15:0] dac_sample,
  output logic dac_valid,
  output logic irq_n
);
  import btg_pkg::*;

  localparam logic [31:0] CLK_W = 32'(CLK_HZ);
  localparam logic [31:0] RATE_W = 32'(BTG_SAMPLE_RATE_HZ);

  // ==========================================================
  // Software registers
  logic [BTG_CTRL_W-1:0] tone_control_reg;
  logic [15:0] tone_freq_coeff;
  logic [15:0] tone_amp_coeff;
  logic [15:0] envelope_step;
  logic [15:0] agc_clip_threshold;
  logic [15:0] on_period_count;
  logic [15:0] off_period_count;
  logic [BTG_IRQ_W-1:0] irq_flag_reg;
  logic [BTG_IRQ_W-1:0] irq_mask_reg;

  // ==========================================================
  // Internal state
  logic [31:0] rate_acc;
  logic [2:0] tick_cnt;
  logic [15:0] volume;
  logic clip_seen;
  btg_cad_e cad_state;
  btg_cad_e next_cad_state;
  logic [15:0] cad_cnt;
  logic [15:0] next_cad_cnt;
  logic on_expire;
  logic off_expire;
  logic signed [15:0] osc_out;

  wire tone_generator_enable = tone_control_reg[BTG_CTRL_EN_BIT];
  wire on_timer_enable = tone_control_reg[BTG_CTRL_ONT_BIT];
  wire off_timer_enable = tone_control_reg[BTG_CTRL_OFFT_BIT];
  wire on_expiry_irq_enable = irq_mask_reg[BTG_IRQ_ON_BIT];
  wire off_expiry_irq_enable = irq_mask_reg[BTG_IRQ_OFF_BIT];
  wire on_expiry_irq_flag = irq_flag_reg[BTG_IRQ_ON_BIT];
  wire off_expiry_irq_flag = irq_flag_reg[BTG_IRQ_OFF_BIT];

  // ==========================================================
  // Bus decode
  wire wr_ctrl = reg_wr && reg_addr == BTG_REG_CTRL;
  wire wr_freq = reg_wr && reg_addr == BTG_REG_FREQ;
  wire wr_amp = reg_wr && reg_addr == BTG_REG_AMP;
  wire wr_step = reg_wr && reg_addr == BTG_REG_STEP;
  wire wr_clip = reg_wr && reg_addr == BTG_REG_CLIP;
  wire wr_oncnt = reg_wr && reg_addr == BTG_REG_ONCNT;
  wire wr_offcnt = reg_wr && reg_addr == BTG_REG_OFFCNT;
  wire wr_mask = reg_wr && reg_addr == BTG_REG_IRQMASK;
  wire rd_flag = reg_rd && reg_addr == BTG_REG_IRQFLAG;

  wire waveform_present = volume != BTG_ZERO16;
  wire [15:0] ctrl_rd_w = 16'({waveform_present, tone_control_reg});
  wire [15:0] rd_mux_w =
    (reg_addr == BTG_REG_CTRL) ? ctrl_rd_w :
    (reg_addr == BTG_REG_FREQ) ? tone_freq_coeff :
    (reg_addr == BTG_REG_AMP) ? tone_amp_coeff :
    (reg_addr == BTG_REG_STEP) ? envelope_step :
    (reg_addr == BTG_REG_CLIP) ? agc_clip_threshold :
    (reg_addr == BTG_REG_ONCNT) ? on_period_count :
    (reg_addr == BTG_REG_OFFCNT) ? off_period_count :
    (reg_addr == BTG_REG_IRQFLAG) ? 16'(irq_flag_reg) :
    (reg_addr == BTG_REG_IRQMASK) ? 16'(irq_mask_reg) :
    (reg_addr == BTG_REG_VOLUME) ? volume : BTG_ZERO16;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tone_control_reg <= '0;
      tone_freq_coeff <= BTG_ZERO16;
      tone_amp_coeff <= BTG_ZERO16;
      envelope_step <= BTG_ZERO16;
      agc_clip_threshold <= BTG_ZERO16;
      on_period_count <= BTG_ZERO16;
      off_period_count <= BTG_ZERO16;
      irq_mask_reg <= '0;
      reg_rdata <= BTG_ZERO16;
    end else if (ce) begin
      if (wr_ctrl) tone_control_reg <= reg_wdata[BTG_CTRL_W-1:0];
      if (wr_freq) tone_freq_coeff <= reg_wdata;
      if (wr_amp) tone_amp_coeff <= reg_wdata;
      if (wr_step) envelope_step <= reg_wdata;
      if (wr_clip) agc_clip_threshold <= reg_wdata;
      if (wr_oncnt) on_period_count <= reg_wdata;
      if (wr_offcnt) off_period_count <= reg_wdata;
      if (wr_mask) irq_mask_reg <= reg_wdata[BTG_IRQ_W-1:0];
      reg_rdata <= reg_rd ? rd_mux_w : BTG_ZERO16;
    end
  end

  // ==========================================================
  // Sample and 125 us tick generation
  wire [31:0] acc_sum_w = rate_acc + RATE_W;
  wire sample_tick = acc_sum_w >= CLK_W;
  wire [31:0] next_acc = sample_tick ? acc_sum_w - CLK_W : acc_sum_w;
  wire env_tick = sample_tick && tick_cnt == BTG_SPT_LAST;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rate_acc <= '0;
      tick_cnt <= '0;
    end else if (ce) begin
      rate_acc <= next_acc;
      if (sample_tick) tick_cnt <= env_tick ? '0 : tick_cnt + 3'(1);
    end
  end

  // ==========================================================
  // Cadence sequencer
  always_comb begin
    next_cad_state = cad_state;
    next_cad_cnt = cad_cnt;
    on_expire = 1'b0;
    off_expire = 1'b0;
    case (cad_state)
      BTG_CAD_IDLE: begin
        if (tone_generator_enable) begin
          next_cad_state = BTG_CAD_ON;
          next_cad_cnt = on_period_count;
        end
      end
      BTG_CAD_ON: begin
        if (!tone_generator_enable) begin
          next_cad_state = BTG_CAD_IDLE;
        end else if (env_tick && on_timer_enable) begin
          if (cad_cnt <= BTG_CNT_LAST) begin
            on_expire = 1'b1;
            next_cad_state = BTG_CAD_OFF;
            next_cad_cnt = off_period_count;
          end else begin
            next_cad_cnt = cad_cnt - BTG_CNT_LAST;
          end
        end
      end
      BTG_CAD_OFF: begin
        if (!tone_generator_enable) begin
          next_cad_state = BTG_CAD_IDLE;
        end else if (env_tick && off_timer_enable) begin
          if (cad_cnt <= BTG_CNT_LAST) begin
            off_expire = 1'b1;
            next_cad_state = BTG_CAD_ON;
            next_cad_cnt = on_period_count;
          end else begin
            next_cad_cnt = cad_cnt - BTG_CNT_LAST;
          end
        end
      end
      default: begin
        next_cad_state = BTG_CAD_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cad_state <= BTG_CAD_IDLE;
      cad_cnt <= BTG_ZERO16;
    end else if (ce) begin
      cad_state <= next_cad_state;
      cad_cnt <= next_cad_cnt;
    end
  end

  wire tone_on = cad_state == BTG_CAD_ON;

  // ==========================================================
  // Interrupt flags, set wins over clear-on-read
  wire [BTG_IRQ_W-1:0] irq_set_w = {off_expire && off_expiry_irq_enable,
                                    on_expire && on_expiry_irq_enable};
  wire [BTG_IRQ_W-1:0] irq_keep_w = rd_flag ? '0 : irq_flag_reg;
  wire [BTG_IRQ_W-1:0] next_irq_flag = irq_set_w | irq_keep_w;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_flag_reg <= '0;
    end else if (ce) begin
      irq_flag_reg <= next_irq_flag;
    end
  end

  assign irq_n = ~(on_expiry_irq_flag | off_expiry_irq_flag);

  // ==========================================================
  // Envelope with clip-detect AGC
  wire [15:0] tx_abs_w = tx_level[15] ? 16'(-tx_level) : tx_level;
  wire clip_now = tx_abs_w > agc_clip_threshold;
  wire clip_halt = clip_now || clip_seen;
  wire [16:0] vol_up_w = {1'b0, volume} + {1'b0, envelope_step};
  wire [15:0] vol_inc_w = (vol_up_w > {1'b0, BTG_VOL_MAX}) ?
                          BTG_VOL_MAX : vol_up_w[15:0];
  wire [15:0] vol_dec_w = (volume < envelope_step) ?
                          BTG_ZERO16 : volume - envelope_step;
  wire [15:0] next_volume = !env_tick ? volume :
                            !tone_on ? vol_dec_w :
                            clip_halt ? volume : vol_inc_w;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      volume <= BTG_ZERO16;
      clip_seen <= 1'b0;
    end else if (ce) begin
      volume <= next_volume;
      clip_seen <= tone_on && clip_halt;
    end
  end

  // ==========================================================
  // Oscillator and DAC product
  wire osc_restart = !tone_on && volume == BTG_ZERO16;

  btg_osc u_osc (
    .core_clk(core_clk),
    .rst(rst),
    .ce(ce),
    .sample_en(sample_tick),
    .restart(osc_restart),
    .coeff(tone_freq_coeff),
    .amp(tone_amp_coeff),
    .osc_out(osc_out)
  );

  wire signed [31:0] dac_prod_w = osc_out * $signed({1'b0, volume[14:0]});
  wire signed [15:0] dac_scaled_w = dac_prod_w[BTG_VOL_SHIFT +: 16];

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dac_sample <= '0;
      dac_valid <= 1'b0;
    end else if (ce) begin
      dac_valid <= sample_tick;
      if (sample_tick) dac_sample <= dac_scaled_w;
    end
  end

  // ==========================================================
  // Checks
  irq_pin_a: assert property (@(posedge core_clk) disable iff (rst)
    irq_n == !(on_expiry_irq_flag || off_expiry_irq_flag))
    else $error("interrupt pin disagrees with flags");

  flag_clear_a: assert property (@(posedge core_clk) disable iff (rst)
    ce && rd_flag && !on_expire && !off_expire |=> irq_flag_reg == '0)
    else $error("flag read did not clear flags");

  mask_gate_a: assert property (@(posedge core_clk) disable iff (rst)
    $rose(on_expiry_irq_flag) |-> $past(on_expiry_irq_enable)
      && $past(on_expire))
    else $error("on flag set while masked");

  expiry_flag_a: assert property (@(posedge core_clk) disable iff (rst)
    ce && off_expire && off_expiry_irq_enable |=> off_expiry_irq_flag)
    else $error("off expiry lost");

  vol_ceiling_a: assert property (@(posedge core_clk) disable iff (rst)
    volume <= BTG_VOL_MAX)
    else $error("volume above ceiling");

  attack_step_a: assert property (@(posedge core_clk) disable iff (rst)
    ce && env_tick && tone_on && !clip_halt
      && vol_up_w <= {1'b0, BTG_VOL_MAX}
      |=> volume == $past(volume) + $past(envelope_step))
    else $error("attack step wrong");

  clip_hold_a: assert property (@(posedge core_clk) disable iff (rst)
    ce && env_tick && tone_on && clip_now |=> volume == $past(volume))
    else $error("ramp not halted by clip");

  decay_step_a: assert property (@(posedge core_clk) disable iff (rst)
    ce && env_tick && !tone_on && volume >= envelope_step
      |=> volume == $past(volume) - $past(envelope_step))
    else $error("decay step wrong");

  present_a: assert property (@(posedge core_clk) disable iff (rst)
    ctrl_rd_w[BTG_CTRL_PRES_BIT] == (volume != BTG_ZERO16))
    else $error("present bit wrong");

  dac_prod_a: assert property (@(posedge core_clk) disable iff (rst)
    ce && sample_tick |=> dac_valid && dac_sample == $past(dac_scaled_w))
    else $error("DAC sample not the product");

  timer_dec_a: assert property (@(posedge core_clk) disable iff (rst)
    ce && env_tick && tone_on && tone_generator_enable && on_timer_enable
      && cad_cnt > BTG_CNT_LAST |=> cad_cnt == $past(cad_cnt) - 16'h0001)
    else $error("on timer did not count");

  cadence_a: assert property (@(posedge core_clk) disable iff (rst)
    ce && on_expire |=> cad_state == BTG_CAD_OFF
      && cad_cnt == $past(off_period_count))
    else $error("off period not started");

endmodule

/* btg_dac_model.sv */
// Behavioural metering DAC that records the incoming sample stream
`timescale 1ns/1ps
module btg_dac_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic dac_valid,
  input wire logic signed [15:0] dac_sample
);
  // ==========================================================
  // Sample history, oldest first, and spacing of the last two
  logic signed [15:0] hist [0:5];
  int gap;
  int run;

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      run <= 0;
      gap <= 0;
    end else if (dac_valid) begin
      gap <= run + 1;
      run <= 0;
      for (int i = 0; i < 5; i++) begin
        hist[i] <= hist[i + 1];
      end
      hist[5] <= dac_sample;
    end else begin
      run <= run + 1;
    end
  end
endmodule

/* btg_bench.sv */
// Self-checking testbench for the billing tone generator
`timescale 1ns/1ps
module billing_tone_generator_bench;
  import btg_pkg::*;
  // ==========================================================
  // Stimulus signals; 640 kHz core setting gives 10 cycles a sample
  localparam int SIM_HZ = 640000;
  localparam int TICK = 80;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [BTG_AW-1:0] reg_addr = 4'h0;
  logic [BTG_DW-1:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [BTG_DW-1:0] reg_rdata;
  logic signed [15:0] tx_level = 16'sh0000;
  logic signed [15:0] dac_sample;
  logic dac_valid;
  logic irq_n;
  int err_count = 0;
  int checked = 0;

  always #5 core_clk = ~core_clk;

  btg_top #(.CLK_HZ(SIM_HZ)) btg_top_inst (
    .core_clk(core_clk),
    .rst(rst),
    .ce(ce),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .tx_level(tx_level),
    .dac_sample(dac_sample),
    .dac_valid(dac_valid),
    .irq_n(irq_n)
  );

  btg_dac_model btg_dac_model_inst (
    .core_clk(core_clk),
    .rst(rst),
    .dac_valid(dac_valid),
    .dac_sample(dac_sample)
  );

  // ==========================================================
  // Shared tasks
  task automatic summarize();
    if (err_count == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // Reads volume one tick apart; up is +1 attack, -1 decay, 0 held
  task automatic ramp_chk(input int up, input int step, input int n);
    logic [15:0] v0;
    logic [15:0] v1;
    int e;
    rd(BTG_REG_VOLUME, v1);
    for (int i = 0; i < n; i++) begin
      v0 = v1;
      cyc(TICK - 2);
      rd(BTG_REG_VOLUME, v1);
      e = int'(v0) + up * step;
      if (e > 32767) e = 32767;
      if (e < 0) e = 0;
      chk("volume", 16'(e), v1);
    end
  endtask

  task automatic wait_irq(input int n);
    int i;
    i = 0;
    while (irq_n !== 1'b0 && i < n) begin
      @(posedge core_clk);
      #1 i++;
    end
    chk("irq_n low", 16'h0000, {15'h0000, irq_n});
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_regs();
    logic [15:0] v;
    rd(BTG_REG_CTRL, v);
    chk("ctrl", 16'h0000, v);
    rd(BTG_REG_VOLUME, v);
    chk("volume", 16'h0000, v);
    chk("irq_n", 16'h0001, {15'h0000, irq_n});
    wr(BTG_REG_FREQ, 16'h1238);
    rd(BTG_REG_FREQ, v);
    chk("freq", 16'h1238, v);
    wr(BTG_REG_VOLUME, 16'h1234);
    rd(BTG_REG_VOLUME, v);
    chk("volume ro", 16'h0000, v);
    wr(4'hf, 16'h5555);
    rd(4'hf, v);
    chk("unmapped", 16'h0000, v);
  endtask

  task automatic t_tone();
    logic [15:0] v;
    logic signed [15:0] pk;
    logic [15:0] h0;
    logic [15:0] h4;
    wr(BTG_REG_CLIP, 16'h7fff);
    wr(BTG_REG_STEP, 16'h1000);
    wr(BTG_REG_AMP, 16'h2000);
    wr(BTG_REG_FREQ, 16'h0000);
    wr(BTG_REG_CTRL, 16'h0001);
    cyc(TICK);
    ramp_chk(1, 16'h1000, 9);
    rd(BTG_REG_CTRL, v);
    chk("present on", 16'h0009, v);
    cyc(70);
    pk = 16'sh0000;
    for (int i = 0; i < 4; i++) begin
      if (btg_dac_model_inst.hist[i] > pk) pk = btg_dac_model_inst.hist[i];
    end
    chk("dac peak", 16'h1fff, pk);
    h0 = btg_dac_model_inst.hist[0];
    h4 = btg_dac_model_inst.hist[4];
    chk("dac cycle", h0, h4);
    chk("dac gap", 16'h000a, 16'(btg_dac_model_inst.gap));
    wr(BTG_REG_CTRL, 16'h0000);
    ramp_chk(-1, 16'h1000, 9);
    rd(BTG_REG_CTRL, v);
    chk("present off", 16'h0000, v);
  endtask

  task automatic t_clip();
    logic [15:0] v;
    wr(BTG_REG_STEP, 16'h0800);
    wr(BTG_REG_CLIP, 16'h0100);
    wr(BTG_REG_CTRL, 16'h0001);
    cyc(2 * TICK);
    tx_level <= 16'sh0400;
    cyc(TICK);
    ramp_chk(0, 16'h0800, 3);
    tx_level <= -16'sh0400;
    ramp_chk(0, 16'h0800, 1);
    tx_level <= 16'sh0000;
    wr(BTG_REG_CTRL, 16'h0000);
    ramp_chk(-1, 16'h0800, 2);
    cyc(4 * TICK);
    rd(BTG_REG_VOLUME, v);
    chk("volume end", 16'h0000, v);
  endtask

  task automatic t_cadence();
    logic [15:0] v;
    wr(BTG_REG_ONCNT, 16'h0003);
    wr(BTG_REG_OFFCNT, 16'h0002);
    wr(BTG_REG_IRQMASK, 16'h0003);
    wr(BTG_REG_CTRL, 16'h0007);
    cyc(150);
    chk("on early", 16'h0001, {15'h0000, irq_n});
    wait_irq(120);
    rd(BTG_REG_IRQFLAG, v);
    chk("on flag", 16'h0001, v);
    chk("irq_n clr", 16'h0001, {15'h0000, irq_n});
    cyc(100);
    chk("off early", 16'h0001, {15'h0000, irq_n});
    wait_irq(100);
    rd(BTG_REG_IRQFLAG, v);
    chk("off flag", 16'h0002, v);
    wr(BTG_REG_CTRL, 16'h0001);
    rd(BTG_REG_IRQFLAG, v);
    cyc(400);
    chk("timers off", 16'h0001, {15'h0000, irq_n});
    wr(BTG_REG_IRQMASK, 16'h0000);
    wr(BTG_REG_CTRL, 16'h0007);
    cyc(800);
    chk("masked", 16'h0001, {15'h0000, irq_n});
    rd(BTG_REG_IRQFLAG, v);
    chk("masked flag", 16'h0000, v);
    wr(BTG_REG_CTRL, 16'h0000);
  endtask

  // ==========================================================
  // Main sequence and watchdog
  initial begin
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    t_regs();
    t_tone();
    t_clip();
    t_cadence();
    summarize();
  end

  initial begin
    #400000;
    err_count++;
    summarize();
  end
endmodule
